// ===== hdl/flash_front.sv
// Serial flash front end: link capture, protection, write timing.
// Assumes an SPI host on csN/sclk/si; sclk is a clock of its own.
//
// Overview of operation
// - Slave in SPI modes 0 and 3 only.
// - Array is 16 sectors of 4K bytes, each erasable alone.
// - Program by 256-byte page; erase by sector or whole chip.
// - Accepted program or erase runs timed; progress shown by busy bit.
// - Page program finishes within 5 ms.
// - Sector erase within 120 ms, chip erase within 2 s.
// - Idle with chip select high means standby.
// - Power-up puts the control machine in standby.
// - Command accepted only as whole bytes ending on a boundary.
// - Altering commands need the write enable latch set.
// - Latch clears at power-up and after disable, status write, program, erase.
// - Protect value 0 protects nothing; 1 to 3 protect everything.
// - Write protect pin low blocks changes to protect and disable bits.
// - Deep power-down ignores all commands but release.
// - Hold starts on hold falling with clock low, else next clock low; here at the second falling clock after hold falls.
// - Hold ends on hold rising with clock low, else next clock low; here at the second falling clock after hold rises.
// - During hold output floats; input and clock ignored.
// - Hold does not stop a running status write, program or erase.
// - Chip select rising during hold resets the link logic.
// - Input sampled on rising clock, output shifted on falling clock.
// - Write-type commands rejected unless select rises on a byte boundary.
// - Unknown command leaves output floating until next select fall.
`timescale 1ns/100ps
module flash_front
  import flash_front_pkg::*;
#(
  parameter int progCycles   = PROG_CYCLES,
  parameter int sectorCycles = SECTOR_CYCLES,
  parameter int chipCycles   = CHIP_CYCLES,
  parameter int statusCycles = STATUS_CYCLES
)(
  // System
  input  wire logic   clk,
  input  wire logic   rst,
  // Serial link
  input  wire logic   sclk,
  input  wire logic   csN,
  input  wire logic   si,
  input  wire logic   holdN,
  input  wire logic   wpN,
  output logic        so,
  output logic        soOe,
  // Core side
  output flashStatus_t status,
  output logic        standby,
  output logic        deepPowerDown,
  output logic        opValid,
  output opReq_t      opStart
);

  // ----------------------------------------
  // Link domain
  // ----------------------------------------
  logic        linkRst;
  logic        fresh;
  logic        holdMeta;
  logic        holdLevel;
  logic [2:0]  bitIdx;
  logic [2:0]  byteCnt;
  logic [2:0]  curBitIdx;
  logic [2:0]  curByteCnt;
  logic [6:0]  shift;
  logic [7:0]  opcode;
  logic [23:0] addr;
  logic [7:0]  dataByte;
  logic        frameTag;
  logic [8:0]  statusMeta;
  logic [8:0]  statusLink;
  logic        readingStatus;

  assign linkRst = rst | csN;

  // Frame start marker, cleared at the first unheld edge
  always_ff @(posedge sclk or posedge linkRst)
  begin
    if (linkRst)
      fresh <= 1'b1;
    else if (holdLevel)
      fresh <= 1'b0;
  end

  always_ff @(negedge sclk or posedge linkRst)
  begin
    if (linkRst)
    begin
      holdMeta  <= 1'b1;
      holdLevel <= 1'b1;
    end
    else
    begin
      holdMeta  <= holdN;
      holdLevel <= holdMeta;
    end
  end

  assign curBitIdx  = fresh ? 3'h0 : bitIdx;
  assign curByteCnt = fresh ? 3'h0 : byteCnt;

  always_ff @(posedge sclk or posedge rst)
  begin
    if (rst)
    begin
      bitIdx   <= 3'h0;
      byteCnt  <= 3'h0;
      shift    <= 7'h00;
      opcode   <= 8'h00;
      addr     <= 24'h000000;
      dataByte <= 8'h00;
      frameTag <= 1'b0;
    end
    else if (holdLevel && !csN)
    begin
      bitIdx <= 3'(curBitIdx + 3'h1);
      shift  <= {shift[5:0], si};
      if (fresh)
        frameTag <= ~frameTag;
      if (curBitIdx == 3'h7)
      begin
        if (curByteCnt != LEN_SAT)
          byteCnt <= 3'(curByteCnt + 3'h1);
        unique case (curByteCnt)
          3'h0: opcode <= {shift, si};
          3'h1:
          begin
            addr[23:16] <= {shift, si};
            dataByte    <= {shift, si};
          end
          3'h2: addr[15:8] <= {shift, si};
          3'h3: addr[7:0]  <= {shift, si};
          default: ;
        endcase
      end
      else if (fresh)
        byteCnt <= 3'h0;
    end
  end

  // Status and deep power-down into the link domain
  always_ff @(posedge sclk or posedge rst)
  begin
    if (rst)
    begin
      statusMeta <= 9'h000;
      statusLink <= 9'h000;
    end
    else
    begin
      statusMeta <= {deepPowerDown, status};
      statusLink <= statusMeta;
    end
  end

  // no status read in deep power-down
  assign readingStatus = ~fresh & (byteCnt != 3'h0)
                       & (opcode == OPC_READ_STATUS) & ~statusLink[8];

  always_ff @(negedge sclk or posedge linkRst)
  begin
    if (linkRst)
    begin
      so   <= 1'b0;
      soOe <= 1'b0;
    end
    else if (!holdLevel)
      soOe <= 1'b0;
    else
    begin
      soOe <= readingStatus;
      so   <= statusLink[3'(3'h7 - bitIdx)];
    end
  end

  // ----------------------------------------
  // System domain
  // ----------------------------------------
  logic       csMeta;
  logic       csSync;
  logic       csLast;
  logic       wpMeta;
  logic       wpSync;
  logic       seenTag;
  logic       frameEnd;
  logic       wholeBytes;
  logic       setWel;
  logic       clrWel;
  logic       enterDeep;
  logic       leaveDeep;
  opKind_t    takeOp;
  coreState_t state;
  logic [31:0] busyCnt;
  logic       write_enable_latch;
  logic [1:0] bp;
  logic       status_write_disable;

  function automatic logic [31:0] cyclesFor(input opKind_t kind);
    unique case (kind)
      OP_STATUS:  cyclesFor = 32'(statusCycles);
      OP_PROGRAM: cyclesFor = 32'(progCycles);
      OP_SECTOR:  cyclesFor = 32'(sectorCycles);
      default:    cyclesFor = 32'(chipCycles);
    endcase
  endfunction : cyclesFor

  // Pin synchronisers
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      csMeta <= 1'b1;
      csSync <= 1'b1;
      csLast <= 1'b1;
      wpMeta <= 1'b1;
      wpSync <= 1'b1;
    end
    else
    begin
      csMeta <= csN;
      csSync <= csMeta;
      csLast <= csSync;
      wpMeta <= wpN;
      wpSync <= wpMeta;
    end
  end

  // Link registers are quiet once select has settled high
  assign frameEnd = csSync & ~csLast & (frameTag != seenTag);

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      seenTag <= 1'b0;
    else if (csSync & ~csLast)
      seenTag <= frameTag;
  end

  // select must rise on a byte boundary
  assign wholeBytes = frameEnd & (bitIdx == 3'h0) & (byteCnt != 3'h0);

  // Command decode at the end of a frame
  always_comb
  begin
    takeOp    = OP_NONE;
    setWel    = 1'b0;
    clrWel    = 1'b0;
    enterDeep = 1'b0;
    leaveDeep = 1'b0;
    if (wholeBytes)
    begin
      if (state == ST_DEEP)
      begin
        if (opcode == OPC_RELEASE)
          leaveDeep = 1'b1;
      end
      else if (state == ST_STANDBY)
      begin
        // any nonzero protect value blocks the array
        case (opcode)
          OPC_WRITE_ENABLE:
            setWel = (byteCnt == LEN_SINGLE);
          OPC_WRITE_DISABLE:
            clrWel = (byteCnt == LEN_SINGLE);
          OPC_STATUS_WRITE:
            if (byteCnt == LEN_STATUS && write_enable_latch)
              takeOp = OP_STATUS;
          OPC_PAGE_PROGRAM:
            if (byteCnt >= LEN_PROG_MIN && write_enable_latch && bp == 2'b00)
              takeOp = OP_PROGRAM;
          OPC_SECTOR_ERASE:
            if (byteCnt == LEN_ADDR && write_enable_latch && bp == 2'b00)
              takeOp = OP_SECTOR;
          OPC_BLOCK_ERASE_A, OPC_BLOCK_ERASE_B:
            if (byteCnt == LEN_ADDR && write_enable_latch && bp == 2'b00)
              takeOp = OP_BLOCK;
          OPC_CHIP_ERASE_A, OPC_CHIP_ERASE_B:
            if (byteCnt == LEN_SINGLE && write_enable_latch && bp == 2'b00)
              takeOp = OP_CHIP;
          OPC_POWER_DOWN:
            enterDeep = (byteCnt == LEN_SINGLE);
          default: ;
        endcase
      end
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      state <= ST_STANDBY;
    else
      unique case (state)
        ST_STANDBY:
          if (takeOp != OP_NONE)
            state <= ST_BUSY;
          else if (enterDeep)
            state <= ST_DEEP;
        ST_BUSY:
          if (busyCnt <= 32'h00000001)
            state <= ST_FINISH;
        ST_FINISH:
          state <= ST_STANDBY;
        ST_DEEP:
          if (leaveDeep)
            state <= ST_STANDBY;
      endcase
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      busyCnt <= 32'h00000000;
    else if (state == ST_STANDBY && takeOp != OP_NONE)
      busyCnt <= cyclesFor(takeOp);
    else if (state == ST_BUSY && busyCnt != 32'h00000000)
      busyCnt <= busyCnt - 32'h00000001;
  end

  // latch clears on disable and on completion
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      write_enable_latch <= 1'b0;
    else if (setWel)
      write_enable_latch <= 1'b1;
    else if (clrWel || state == ST_FINISH)
      write_enable_latch <= 1'b0;
  end

  // write protect pin freezes protect bits
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      bp   <= STATUS_RESET.blockProtect;
      status_write_disable <= STATUS_RESET.statusWriteDisable;
    end
    else if (takeOp == OP_STATUS && wpSync)
    begin
      bp   <= dataByte[3:2];
      status_write_disable <= dataByte[7];
    end
  end

  // standby shown when idle and deselected
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      status        <= STATUS_RESET;
      standby       <= 1'b1;
      deepPowerDown <= 1'b0;
    end
    else
    begin
      status.writeInProgress    <= (state == ST_BUSY) | (state == ST_FINISH);
      status.writeEnableLatch   <= write_enable_latch;
      status.blockProtect       <= bp;
      status.statusWriteDisable <= status_write_disable;
      status.reserved           <= 3'h0;
      standby                   <= (state == ST_STANDBY) & csSync;
      deepPowerDown             <= (state == ST_DEEP);
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      opValid <= 1'b0;
      opStart <= '0;
    end
    else
    begin
      opValid <= (state == ST_STANDBY) & (takeOp != OP_NONE);
      if (state == ST_STANDBY && takeOp != OP_NONE)
      begin
        opStart.kind <= takeOp;
        unique case (takeOp)
          OP_PROGRAM: opStart.addr <= {addr[15:PAGE_LSB], 8'h00};
          OP_SECTOR:  opStart.addr <= {addr[15:SECTOR_LSB], 12'h000};
          default:    opStart.addr <= 16'h0000;
        endcase
      end
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  welFinish_a: assert property (@(posedge clk) disable iff (rst)
    state == ST_FINISH |=> !write_enable_latch)
    else $error("latch not cleared after operation");

  wpFreeze_a: assert property (@(posedge clk) disable iff (rst)
    (takeOp == OP_STATUS && !wpSync) |=> $stable(bp) && $stable(status_write_disable))
    else $error("protect bits changed with pin low");

  deepStay_a: assert property (@(posedge clk) disable iff (rst)
    (state == ST_DEEP && !leaveDeep) |=> state == ST_DEEP)
    else $error("deep power-down left without release");

  protectAll_a: assert property (@(posedge clk) disable iff (rst)
    (bp != 2'b00) |-> !(takeOp inside {OP_PROGRAM, OP_SECTOR, OP_BLOCK, OP_CHIP}))
    else $error("array change accepted while protected");

  byteBound_a: assert property (@(posedge clk) disable iff (rst)
    (takeOp != OP_NONE || setWel || enterDeep) |-> bitIdx == 3'h0)
    else $error("command accepted off a byte boundary");

  welNeed_a: assert property (@(posedge clk) disable iff (rst)
    takeOp != OP_NONE |-> write_enable_latch)
    else $error("altering command without latch");

  busyFlag_a: assert property (@(posedge clk) disable iff (rst)
    (state == ST_STANDBY && takeOp != OP_NONE) |=> ##1 status.writeInProgress)
    else $error("busy bit not raised");

  progLoad_a: assert property (@(posedge clk) disable iff (rst)
    (state == ST_STANDBY && takeOp == OP_PROGRAM) |=> busyCnt == 32'(progCycles))
    else $error("program time not loaded");

  standbyOut_a: assert property (@(posedge clk) disable iff (rst)
    (state == ST_STANDBY && csSync) |=> standby)
    else $error("standby not shown");

  holdQuiet_a: assert property (@(negedge sclk) disable iff (linkRst)
    !holdLevel |=> !soOe)
    else $error("output driven during hold");

  progSeen_c: cover property (@(posedge clk) disable iff (rst)
    opValid && opStart.kind == OP_PROGRAM);
  deepSeen_c: cover property (@(posedge clk) disable iff (rst)
    state == ST_DEEP ##[1:1000] state == ST_STANDBY);
  statusRead_c: cover property (@(negedge sclk) disable iff (linkRst)
    soOe ##1 !holdLevel);

endmodule : flash_front

// ===== hdl/flash_front_pkg.sv
// Constants and types of the serial flash front end.
// Assumes a 100 MHz system clock beside the serial link.
package flash_front_pkg;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_MHZ           = 100;
  localparam int PROG_TIME_US      = 1400;
  localparam int SECTOR_TIME_US    = 60000;
  localparam int CHIP_TIME_US      = 1000000;
  localparam int STATUS_TIME_US    = 10;
  localparam int PROG_CYCLES       = PROG_TIME_US * CLK_MHZ;
  localparam int SECTOR_CYCLES     = SECTOR_TIME_US * CLK_MHZ;
  localparam int CHIP_CYCLES       = CHIP_TIME_US * CLK_MHZ;
  localparam int STATUS_CYCLES     = STATUS_TIME_US * CLK_MHZ;

  // ----------------------------------------
  // Array layout
  // ----------------------------------------
  localparam int SECTOR_LSB        = 12;
  localparam int PAGE_LSB          = 8;
  localparam int ARRAY_ADDR_BITS   = 16;

  // ----------------------------------------
  // Command codes
  // ----------------------------------------
  localparam logic [7:0] OPC_WRITE_ENABLE  = 8'h06;
  localparam logic [7:0] OPC_WRITE_DISABLE = 8'h04;
  localparam logic [7:0] OPC_READ_STATUS   = 8'h05;
  localparam logic [7:0] OPC_STATUS_WRITE  = 8'h01;
  localparam logic [7:0] OPC_PAGE_PROGRAM  = 8'h02;
  localparam logic [7:0] OPC_SECTOR_ERASE  = 8'h20;
  localparam logic [7:0] OPC_BLOCK_ERASE_A = 8'h52;
  localparam logic [7:0] OPC_BLOCK_ERASE_B = 8'hd8;
  localparam logic [7:0] OPC_CHIP_ERASE_A  = 8'h60;
  localparam logic [7:0] OPC_CHIP_ERASE_B  = 8'hc7;
  localparam logic [7:0] OPC_POWER_DOWN    = 8'hb9;
  localparam logic [7:0] OPC_RELEASE       = 8'hab;

  // Byte counts of whole commands
  localparam logic [2:0] LEN_SINGLE   = 3'h1;
  localparam logic [2:0] LEN_STATUS   = 3'h2;
  localparam logic [2:0] LEN_ADDR     = 3'h4;
  localparam logic [2:0] LEN_PROG_MIN = 3'h5;
  localparam logic [2:0] LEN_SAT      = 3'h7;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef struct packed {
    logic       statusWriteDisable;
    logic [2:0] reserved;
    logic [1:0] blockProtect;
    logic       writeEnableLatch;
    logic       writeInProgress;
  } flashStatus_t;

  localparam flashStatus_t STATUS_RESET = 8'h00;

  typedef enum logic [2:0] {
    OP_NONE, OP_STATUS, OP_PROGRAM, OP_SECTOR, OP_BLOCK, OP_CHIP
  } opKind_t;

  typedef struct packed {
    opKind_t                    kind;
    logic [ARRAY_ADDR_BITS-1:0] addr;
  } opReq_t;

  typedef enum logic [1:0] {
    ST_STANDBY = 2'b00,
    ST_BUSY    = 2'b01,
    ST_FINISH  = 2'b11,
    ST_DEEP    = 2'b10
  } coreState_t;

endpackage : flash_front_pkg

// ===== tb/spi_host.sv
// SPI host model driving the serial link in mode 0 or mode 3.
// Assumes the bench calls frame; link clock 6 ns, still between frames.
`timescale 1ns/100ps
module spi_host (
  // Serial link
  output logic      sclk,
  output logic      csN,
  output logic      si,
  output logic      holdN,
  input  wire logic so
);
  initial
  begin
    sclk  = 1'b0;
    csN   = 1'b1;
    si    = 1'b0;
    holdN = 1'b1;
  end

  task automatic frame(input logic [39:0] data, input int nbits, input bit cut,
                       input bit mode3, output logic [7:0] rd);
    rd   = 8'h00;
    sclk = mode3;
    #3 csN = 1'b0;
    for (int i = 0; i < nbits; i++)
    begin
      if (mode3)
        #3 sclk = 1'b0;
      si = data[39 - i];
      #3 sclk = 1'b1;
      rd = {rd[6:0], so};
      if (!mode3)
        #3 sclk = 1'b0;
    end
    #3;
    if (cut)
    begin
      holdN = 1'b0;
      repeat (4)
      begin
        #3 sclk = ~sclk;
        #3 sclk = ~sclk;
      end
      csN = 1'b1;
      #6 holdN = 1'b1;
    end
    else
      csN = 1'b1;
    // Released input shows inverse, not last value
    si = ~si;
  endtask : frame
endmodule : spi_host

// ===== tb/test_serial_flash_protect_hold_front_end.sv
// Self-checking bench of the serial flash front end.
// Assumes spi_host as link partner and shortened busy counts.
`timescale 1ns/100ps
module test_serial_flash_protect_hold_front_end
  import flash_front_pkg::*;
;
  localparam int PROG = 20;
  localparam int SECT = 30;
  localparam int CHIP = 40;
  localparam int STAT = 10;
  localparam logic [7:0] OPS  [6] = '{8'h02, 8'h20, 8'h52, 8'hd8, 8'h60, 8'hc7};
  localparam int         BITS [6] = '{40, 32, 32, 32, 8, 8};
  localparam int         LSBS [6] = '{PAGE_LSB, SECTOR_LSB, 16, 16, 16, 16};
  localparam int         BUSY [6] = '{PROG + 1, SECT + 1, CHIP + 1, CHIP + 1,
                                      CHIP + 1, CHIP + 1};
  localparam opKind_t    KIND [6] = '{OP_PROGRAM, OP_SECTOR, OP_BLOCK, OP_BLOCK,
                                      OP_CHIP, OP_CHIP};

  logic         clk;
  logic         rst;
  logic         wpN;
  logic         sclk;
  logic         csN;
  logic         si;
  logic         holdN;
  logic         so;
  logic         soOe;
  flashStatus_t status;
  logic         standby;
  logic         deepPowerDown;
  logic         opValid;
  opReq_t       opStart;
  logic [7:0]   rd;
  logic [31:0]  seed        = 32'h278fab95;
  int           errorCnt    = 0;
  int           comparisons = 0;
  int           opCount     = 0;
  int           run         = 0;
  int           lastBusy    = 0;
  bit           mode3       = 1'b0;

  flash_front #(.progCycles(PROG), .sectorCycles(SECT), .chipCycles(CHIP),
                .statusCycles(STAT)) dut (
    .clk(clk), .rst(rst), .sclk(sclk), .csN(csN), .si(si), .holdN(holdN),
    .wpN(wpN), .so(so), .soOe(soOe), .status(status), .standby(standby),
    .deepPowerDown(deepPowerDown), .opValid(opValid), .opStart(opStart)
  );

  spi_host host (.sclk(sclk), .csN(csN), .si(si), .holdN(holdN), .so(so));

  // ----------------------------------------
  // Monitors and helpers
  // ----------------------------------------
  always @(posedge clk)
  begin
    if (opValid === 1'b1)
      opCount <= opCount + 1;
    if (status.writeInProgress === 1'b1)
      run <= run + 1;
    else if (run != 0)
    begin
      lastBusy <= run;
      run      <= 0;
    end
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  function automatic logic [7:0] expSt(input logic [1:0] bp, input logic write_enable_latch,
                                       input logic write_in_progress);
    return {4'h0, bp, write_enable_latch, write_in_progress};
  endfunction : expSt

  function automatic logic [15:0] align(input logic [15:0] a, input int lsb);
    return (lsb > 15) ? 16'h0000 : a & (16'hffff << lsb);
  endfunction : align

  task automatic summarize;
    $display("errors=%0d comparisons=%0d", errorCnt, comparisons);
    if (errorCnt == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : summarize

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      errorCnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic send(input logic [39:0] data, input int nbits, input bit cut = 0);
    @(negedge clk);
    #0.7;
    host.frame(data, nbits, cut, mode3, rd);
    repeat (6) @(negedge clk);
  endtask : send

  task automatic waitIdle;
    int n;
    n = 0;
    while (status.writeInProgress !== 1'b0 && n < 500)
    begin
      @(negedge clk);
      n++;
    end
    if (n >= 500)
    begin
      errorCnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, n, 0);
      summarize();
    end
    repeat (2) @(negedge clk);
  endtask : waitIdle

  task automatic wrStatus(input logic [7:0] v);
    send(40'h0600000000, 8);
    send({8'h01, v, 24'h000000}, 16);
    waitIdle();
  endtask : wrStatus

  // ----------------------------------------
  // Clock, watchdog and scenarios
  // ----------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial
  begin
    #900000;
    errorCnt++;
    summarize();
  end

  initial
  begin
    int c;
    rst = 1'b1;
    wpN = 1'b1;
    repeat (3) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    check({standby, deepPowerDown, opValid}, 3'b100);
    check(status, expSt(2'b00, 1'b0, 1'b0));
    send(40'h0600000000, 8);
    check(status, expSt(2'b00, 1'b1, 1'b0));
    send(40'h0500000000, 16);
    check(rd, expSt(2'b00, 1'b1, 1'b0));
    check(soOe, 1'b0);
    send(40'h0400000000, 8);
    check(status, expSt(2'b00, 1'b0, 1'b0));
    send(40'h06ff000000, 7);
    send(40'h06ff000000, 9);
    check(status, expSt(2'b00, 1'b0, 1'b0));
    send(40'h0600000000, 8, 1);
    check(status, expSt(2'b00, 1'b0, 1'b0));
    c = opCount;
    send({8'h02, 8'h00, seed[15:0], seed[23:16]}, 40);
    check(opCount - c, 0);
    for (int k = 0; k < 6; k++)
    begin
      seed = lfsr(seed);
      mode3 = k[0];
      send(40'h0600000000, 8);
      c = opCount;
      send({OPS[k], 8'h00, seed[15:0], seed[23:16]}, BITS[k]);
      check(opCount - c, 1);
      check({13'h0000, opStart}, {13'h0000, KIND[k], align(seed[15:0], LSBS[k])});
      check(status, expSt(2'b00, 1'b1, 1'b1));
      send(40'h0500000000, 12, 1);
      waitIdle();
      check(lastBusy, BUSY[k]);
      check(status, expSt(2'b00, 1'b0, 1'b0));
      send(40'h0500000000, 16);
      check(rd, expSt(2'b00, 1'b0, 1'b0));
    end
    for (int b = 1; b < 4; b++)
    begin
      wrStatus({4'h0, 2'(b), 2'b00});
      check(status, expSt(2'(b), 1'b0, 1'b0));
      check(lastBusy, STAT + 1);
      send(40'h0600000000, 8);
      c = opCount;
      send({8'h20, 8'h00, seed[15:0], 8'h00}, 32);
      check(opCount - c, 0);
    end
    wpN = 1'b0;
    wrStatus(8'h80);
    check(status, expSt(2'b11, 1'b0, 1'b0));
    wpN = 1'b1;
    wrStatus(8'h00);
    check(status, expSt(2'b00, 1'b0, 1'b0));
    send(40'hb900000000, 8);
    check(deepPowerDown, 1'b1);
    send(40'h0600000000, 8);
    check(status, expSt(2'b00, 1'b0, 1'b0));
    send(40'hab00000000, 8);
    check(deepPowerDown, 1'b0);
    send(40'h0600000000, 8);
    check(status, expSt(2'b00, 1'b1, 1'b0));
    check(standby, 1'b1);
    summarize();
  end
endmodule : test_serial_flash_protect_hold_front_end
